//--- core/cdv_phase.sv
// input edge detection and half-cycle phase counter of the divider
`timescale 1ns/1ns
module cdv_phase
(
	input wire logic ref_clk,
	input wire logic clr_n,
	input wire logic in_clk,
	input wire logic div_sel,
	output logic in_rise,
	output logic in_fall,
	output logic [cdv_pkg::PH_W-1:0] ph,
	output logic ratio_hi,
	output logic phase_hi,
	output logic period_start,
	output logic running
);
	logic in_prev_ff;
	logic nxt_in_prev;
	logic run_ff;
	logic nxt_run;
	logic sel_ff;
	logic nxt_sel;
	logic [cdv_pkg::PH_W-1:0] ph_ff;
	logic [cdv_pkg::PH_W-1:0] nxt_ph;
	logic [cdv_pkg::PH_W-1:0] half;
	logic [cdv_pkg::PH_W-1:0] last;
	logic wrap;

	// ratio is latched only at a period boundary so a change never cuts a pulse short
	always_comb
	begin
		in_rise = in_clk & ~in_prev_ff;
		in_fall = ~in_clk & in_prev_ff;
		nxt_in_prev = in_clk;
		half = sel_ff ? cdv_pkg::DIV_HI : cdv_pkg::DIV_LO;
		last = sel_ff ? cdv_pkg::LAST_HI : cdv_pkg::LAST_LO;
		wrap = in_rise & (~run_ff | (ph_ff == last));
		nxt_run = run_ff | in_rise;
		nxt_sel = wrap ? div_sel : sel_ff;
		nxt_ph = ph_ff;
		if (wrap)
			nxt_ph = cdv_pkg::PH_RST;
		else if (run_ff & (in_rise | in_fall))
			nxt_ph = ph_ff + 4'h1;
		phase_hi = nxt_run & (nxt_ph < (wrap ? cdv_pkg::DIV_LO : half));
		period_start = wrap;
	end

	// counting waits for the first rising edge so periods always begin on a rise
	always_ff @(posedge ref_clk or negedge clr_n)
	begin
		if (!clr_n)
		begin
			in_prev_ff <= 1'b0;
			run_ff <= 1'b0;
			sel_ff <= cdv_pkg::PIN_PULL;
			ph_ff <= cdv_pkg::PH_RST;
		end
		else
		begin
			in_prev_ff <= nxt_in_prev;
			run_ff <= nxt_run;
			sel_ff <= nxt_sel;
			ph_ff <= nxt_ph;
		end
	end

	assign ph = ph_ff;
	assign ratio_hi = sel_ff;
	assign running = run_ff;
endmodule

//--- core/cdv_pkg.sv
// constants, state codes and rule summary for the divide-by-3/5 clock divider
// Function
// - divider state advances on both rising and falling input clock edges
// - divide by three: output falls at falling edge of second input cycle
// - divide by five: output falls at falling edge of third input cycle
// - enabling resumes output only after one input rise then one input fall
// - disabling stops output after input rise then output fall, leaving it low
// - gating never truncates a pulse; each pulse keeps full width for the ratio
// - gate control reads high when unconnected, so output is enabled by default
// - ratio select low divides by three, high by five; unconnected reads high
package cdv_pkg;
	// width of the half-cycle phase counter
	localparam int PH_W = 4;
	// output high time in input half-cycles per ratio
	localparam logic [PH_W-1:0] DIV_LO = 4'h3;
	localparam logic [PH_W-1:0] DIV_HI = 4'h5;
	// last phase index of an output period, twice the ratio minus one
	localparam logic [PH_W-1:0] LAST_LO = 4'h5;
	localparam logic [PH_W-1:0] LAST_HI = 4'h9;
	localparam logic [PH_W-1:0] PH_RST = 4'h0;
	// output levels while cleared
	localparam logic Q_RST = 1'b0;
	localparam logic QN_RST = 1'b1;
	// level an unconnected strap pin settles to through its pull-up
	localparam logic PIN_PULL = 1'b1;

	// output gate sequencing, one-hot
	typedef enum logic [6:0] {
		CDV_OFF = 7'h01,
		CDV_ARM_R = 7'h02,
		CDV_ARM_F = 7'h04,
		CDV_SYNC = 7'h08,
		CDV_ON = 7'h10,
		CDV_DR_R = 7'h20,
		CDV_DR_F = 7'h40
	} cdv_gate_t;
endpackage

//--- core/cdv_top.sv
// divide-by-3/5 clock divider with glitch-free synchronous output gate
`timescale 1ns/1ns
module cdv_top
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic master_clear_n,
	input wire logic in_clk,
	input wire logic div_sel,
	input wire logic out_en,
	output logic div_clk,
	output logic div_clk_n
);
	logic clr_n;
	logic in_rise;
	logic in_fall;
	logic [cdv_pkg::PH_W-1:0] ph;
	logic ratio_hi;
	logic phase_hi;
	logic period_start;
	logic running;
	cdv_pkg::cdv_gate_t state_ff;
	cdv_pkg::cdv_gate_t nxt_state;
	logic div_clk_ff;
	logic nxt_div_clk;
	logic div_clk_n_ff;
	logic nxt_div_clk_n;

	// either reset clears everything at once, without waiting for a clock
	assign clr_n = rst_n & master_clear_n;

	cdv_phase u_phase
	(
		.ref_clk(ref_clk),
		.clr_n(clr_n),
		.in_clk(in_clk),
		.div_sel(div_sel),
		.in_rise(in_rise),
		.in_fall(in_fall),
		.ph(ph),
		.ratio_hi(ratio_hi),
		.phase_hi(phase_hi),
		.period_start(period_start),
		.running(running)
	);

	// gate sequencing; a drop of the enable while arming simply aborts the arm
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			cdv_pkg::CDV_OFF:
			begin
				if (out_en)
					nxt_state = cdv_pkg::CDV_ARM_R;
			end
			cdv_pkg::CDV_ARM_R:
			begin
				if (!out_en)
					nxt_state = cdv_pkg::CDV_OFF;
				else if (in_rise)
					nxt_state = cdv_pkg::CDV_ARM_F;
			end
			cdv_pkg::CDV_ARM_F:
			begin
				if (!out_en)
					nxt_state = cdv_pkg::CDV_OFF;
				else if (in_fall)
					nxt_state = cdv_pkg::CDV_SYNC;
			end
			cdv_pkg::CDV_SYNC:
			begin
				// start only on a period boundary so the first pulse is whole
				if (!out_en)
					nxt_state = cdv_pkg::CDV_OFF;
				else if (period_start)
					nxt_state = cdv_pkg::CDV_ON;
			end
			cdv_pkg::CDV_ON:
			begin
				if (!out_en)
					nxt_state = cdv_pkg::CDV_DR_R;
			end
			cdv_pkg::CDV_DR_R:
			begin
				if (out_en)
					nxt_state = cdv_pkg::CDV_ON;
				else if (in_rise)
					nxt_state = cdv_pkg::CDV_DR_F;
			end
			cdv_pkg::CDV_DR_F:
			begin
				// if the output is low here one more full pulse runs before the stop
				if (out_en)
					nxt_state = cdv_pkg::CDV_ON;
				else if (div_clk_ff && !phase_hi)
					nxt_state = cdv_pkg::CDV_OFF;
			end
			default:
			begin
				nxt_state = cdv_pkg::CDV_OFF;
			end
		endcase
	end

	// output follows the phase only while the gate is open; otherwise held low
	always_comb
	begin
		nxt_div_clk = 1'b0;
		if (nxt_state == cdv_pkg::CDV_ON || nxt_state == cdv_pkg::CDV_DR_R ||
			nxt_state == cdv_pkg::CDV_DR_F)
			nxt_div_clk = phase_hi;
		nxt_div_clk_n = ~nxt_div_clk;
	end

	// output and gate registers
	always_ff @(posedge ref_clk or negedge clr_n)
	begin
		if (!clr_n)
		begin
			state_ff <= cdv_pkg::CDV_OFF;
			div_clk_ff <= cdv_pkg::Q_RST;
			div_clk_n_ff <= cdv_pkg::QN_RST;
		end
		else
		begin
			state_ff <= nxt_state;
			div_clk_ff <= nxt_div_clk;
			div_clk_n_ff <= nxt_div_clk_n;
		end
	end

	assign div_clk = div_clk_ff;
	assign div_clk_n = div_clk_n_ff;

	// every input edge, rising or falling, moves the phase while running
	edge_both_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		(running && (in_rise || in_fall)) |=> (ph != $past(ph)))
		else $error("phase did not advance on an input edge");

	// divide by three: output falls on an input fall at phase three
	div3_fall_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		($fell(div_clk_ff) && !ratio_hi) |-> ((ph == cdv_pkg::DIV_LO) && $past(in_fall)))
		else $error("divide by three output fell at the wrong input edge");

	// divide by five: output falls on an input fall at phase five
	div5_fall_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		($fell(div_clk_ff) && ratio_hi) |-> ((ph == cdv_pkg::DIV_HI) && $past(in_fall)))
		else $error("divide by five output fell at the wrong input edge");

	// arming needs a rise first, then a fall
	arm_rise_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		((state_ff == cdv_pkg::CDV_ARM_F) && ($past(state_ff) == cdv_pkg::CDV_ARM_R))
		|-> $past(in_rise))
		else $error("arming advanced without an input rise");

	arm_fall_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		((state_ff == cdv_pkg::CDV_SYNC) && ($past(state_ff) == cdv_pkg::CDV_ARM_F))
		|-> $past(in_fall))
		else $error("arming advanced without an input fall");

	// no output pulse may appear before the arming sequence is complete
	no_early_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		(state_ff == cdv_pkg::CDV_OFF || state_ff == cdv_pkg::CDV_ARM_R ||
		state_ff == cdv_pkg::CDV_ARM_F || state_ff == cdv_pkg::CDV_SYNC) |-> !div_clk_ff)
		else $error("output active while gate closed");

	// stopping happens exactly at an output falling edge and leaves it low
	stop_low_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		((state_ff == cdv_pkg::CDV_OFF) && ($past(state_ff) == cdv_pkg::CDV_DR_F))
		|-> (!div_clk_ff && $past(div_clk_ff)))
		else $error("output stopped other than on its falling edge");

	// every pulse starts at phase zero, so with the fall checks it is full width
	full_pulse_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		$rose(div_clk_ff) |-> ((ph == cdv_pkg::PH_RST) && $past(in_rise)))
		else $error("output pulse started mid-period");

	// an enable seen high in the off state starts arming next cycle
	en_default_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		((state_ff == cdv_pkg::CDV_OFF) && out_en) |=> (state_ff == cdv_pkg::CDV_ARM_R))
		else $error("enable high did not start arming");

	// ratio select is captured at each period boundary
	ratio_sel_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		period_start |=> (ratio_hi == $past(div_sel)))
		else $error("ratio select not captured at period start");

	// while cleared the outputs rest low and high
	clear_out_a: assert property (@(posedge ref_clk)
		!clr_n |-> (!div_clk_ff && div_clk_n_ff && (ph == cdv_pkg::PH_RST)))
		else $error("outputs not in cleared state during reset");

	// the pair always stays complementary
	compl_pair_a: assert property (@(posedge ref_clk) disable iff (!clr_n)
		div_clk_n_ff == !div_clk_ff)
		else $error("complement output not inverse of true output");

	// main scenarios
	div3_pulse_c: cover property (@(posedge ref_clk) disable iff (!clr_n)
		$fell(div_clk_ff) && !ratio_hi);
	div5_pulse_c: cover property (@(posedge ref_clk) disable iff (!clr_n)
		$fell(div_clk_ff) && ratio_hi);
	enable_done_c: cover property (@(posedge ref_clk) disable iff (!clr_n)
		(state_ff == cdv_pkg::CDV_SYNC) ##1 (state_ff == cdv_pkg::CDV_ON));
	drain_done_c: cover property (@(posedge ref_clk) disable iff (!clr_n)
		(state_ff == cdv_pkg::CDV_DR_F) ##1 (state_ff == cdv_pkg::CDV_OFF));
endmodule

//--- tb/cdv_src.sv
// free-running input clock source that feeds the divider
`timescale 1ns/1ns
module cdv_src
#(
	parameter int HALF = 2
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	output logic in_clk
);
	int cnt_ff;
	logic clk_ff;

	// a half-period of at least one ref_clk cycle keeps every edge visible to the divider
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 0;
			clk_ff <= 1'b0;
		end
		else if (cnt_ff == HALF - 1)
		begin
			cnt_ff <= 0;
			clk_ff <= ~clk_ff;
		end
		else
			cnt_ff <= cnt_ff + 1;
	end

	assign in_clk = clk_ff;
endmodule

//--- tb/cdv_top_tb.sv
// self-checking testbench for the divide-by-3/5 clock divider
`timescale 1ns/1ns
module cdv_top_tb;
	localparam int HALF = 2;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b1;
	logic master_clear_n = 1'b1;
	logic div_sel = 1'b0;
	logic out_en = 1'b1;
	logic in_clk;
	logic div_clk;
	logic div_clk_n;
	logic [7:0] n;
	int num_errors = 0;
	int checks_done = 0;

	always #5 ref_clk = ~ref_clk;

	cdv_src #(.HALF(HALF)) src (.ref_clk(ref_clk), .rst_n(rst_n), .in_clk(in_clk));

	cdv_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .master_clear_n(master_clear_n),
		.in_clk(in_clk), .div_sel(div_sel), .out_en(out_en), .div_clk(div_clk),
		.div_clk_n(div_clk_n));

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// sample 1 ns after the next rising edge so the design's updates have landed
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask

	// bounded wait for a level on the divided clock
	task automatic wait_lvl(input logic lvl);
		int k;
		k = 0;
		while (div_clk !== lvl)
		begin
			if (k == 100)
			begin
				num_errors++;
				$display("unexpected at %0t: timeout got %0h expected %0h", $time, div_clk, lvl);
				end_sim();
			end
			k++;
			step();
		end
	endtask

	// cycles the output holds a level, capped at 40
	task automatic cnt(input logic lvl, output logic [7:0] c);
		c = 8'h00;
		while (div_clk === lvl && c < 8'h28)
		begin
			c++;
			step();
		end
	endtask

	task automatic t_div3();
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		chk({7'h00, div_clk_n}, 8'h00);
		cnt(1'b1, n);
		chk(n, 8'(3 * HALF));
		cnt(1'b0, n);
		chk(n, 8'(3 * HALF));
		$display("test div3 done");
	endtask

	// disable in mid-pulse: the pulse must keep its width, then the output stays low
	task automatic t_off();
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		@(posedge ref_clk) out_en <= 1'b0;
		#1;
		cnt(1'b1, n);
		chk(n + 8'h01, 8'(3 * HALF));
		cnt(1'b0, n);
		chk(n, 8'h28);
		$display("test disable done");
	endtask

	task automatic t_on();
		@(posedge ref_clk) out_en <= 1'b1;
		#1;
		step();
		chk({7'h00, div_clk}, 8'h00);
		wait_lvl(1'b1);
		cnt(1'b1, n);
		chk(n, 8'(3 * HALF));
		cnt(1'b0, n);
		chk(n, 8'(3 * HALF));
		$display("test enable done");
	endtask

	// disable while the output is low: one more whole pulse runs, then it stays low
	task automatic t_off_low();
		wait_lvl(1'b0);
		@(posedge ref_clk) out_en <= 1'b0;
		#1;
		wait_lvl(1'b1);
		cnt(1'b1, n);
		chk(n, 8'(3 * HALF));
		cnt(1'b0, n);
		chk(n, 8'h28);
		@(posedge ref_clk) out_en <= 1'b1;
		#1;
		wait_lvl(1'b1);
		cnt(1'b1, n);
		chk(n, 8'(3 * HALF));
		$display("test disable while low done");
	endtask

	task automatic t_div5();
		@(posedge ref_clk) div_sel <= 1'b1;
		#1;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		cnt(1'b1, n);
		chk(n, 8'(5 * HALF));
		cnt(1'b0, n);
		chk(n, 8'(5 * HALF));
		$display("test div5 done");
	endtask

	// clear while the output is high, then a full pulse after release
	task automatic t_clear();
		wait_lvl(1'b1);
		@(posedge ref_clk) master_clear_n <= 1'b0;
		#1;
		chk({6'h00, div_clk, div_clk_n}, 8'h01);
		repeat (4) step();
		chk({6'h00, div_clk, div_clk_n}, 8'h01);
		@(posedge ref_clk) master_clear_n <= 1'b1;
		#1;
		wait_lvl(1'b1);
		cnt(1'b1, n);
		chk(n, 8'(5 * HALF));
		$display("test clear done");
	endtask

	// gate held high stands for the open pin
	initial
	begin
		// clear lands after every process waits, so its falling edge is never missed
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_div3();
		t_off();
		t_on();
		t_off_low();
		t_div5();
		t_clear();
		end_sim();
	end
endmodule
